// File: include/text_display_pkg.sv
// Constants, field layouts and carrier types for the text display command port.
// Notes on behaviour
// - Bus width bit high: whole bytes move in a single transfer.
// - Bus width bit low: each byte moves as two 4-bit transfers.
// - Line count bit picks one-line (low) or two-line (high) operation.
// - Font bit picks 5x8 (low) or 5x11 (high) character cells.
// - Byte 01xxxxxx loads six address bits and selects glyph pattern RAM.
// - Byte 1xxxxxxx loads seven address bits and selects display text RAM.
// - One-line mode text addresses run 00H through 4FH.
// - Two-line mode: line one 00H-27H, line two 40H-67H.
// - Instruction read returns busy on bit 7, address counter below.
// - Data write stores into the last selected RAM at the counter.
// - Each data write steps the counter by one in entry direction.
// - Data read returns a byte from the last selected RAM.
// - First read without a prior address load is invalid; host drops it.
// - Cursor shift reloads the read register from text RAM only while text RAM is selected.
// - Each data read steps the counter by one in entry direction.
// - Read after a write returns the old read register contents.
// - Positions 1-16 show addresses 00-0F and 40-4F.
// - Entry direction high counts up, low counts down.
// - Instruction writes hold busy for 39 us.
// - Data reads and writes hold busy for 43 us.
package text_display_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int T_INSTR_NS    = 39000;
  localparam int T_DATA_NS     = 43000;
  localparam int BUSY_W        = 16;
  localparam logic [BUSY_W-1:0] INSTR_CYC =
    BUSY_W'(T_INSTR_NS / CLK_PERIOD_NS);
  localparam logic [BUSY_W-1:0] DATA_CYC =
    BUSY_W'(T_DATA_NS / CLK_PERIOD_NS);

  localparam int TEXT_DEPTH  = 128;
  localparam int GLYPH_DEPTH = 64;

  localparam logic [6:0] ADDR_FIRST   = 7'h00;
  localparam logic [6:0] ONE_LINE_END = 7'h4f;
  localparam logic [6:0] LINE1_END    = 7'h27;
  localparam logic [6:0] LINE2_START  = 7'h40;
  localparam logic [6:0] LINE2_END    = 7'h67;
  localparam logic [6:0] ADDR_ONE     = 7'h01;

  localparam int BIT_TEXT_SET  = 7;
  localparam int BIT_GLYPH_SET = 6;
  localparam int BIT_FUNC_SET  = 5;
  localparam int BIT_SHIFT_OP  = 4;
  localparam int BIT_BUS8      = 4;
  localparam int BIT_LINES     = 3;
  localparam int BIT_FONT      = 2;
  localparam int BIT_SHIFT_SC  = 3;
  localparam int BIT_SHIFT_RL  = 2;

  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam int CTRL_UP_BIT   = 0;
  localparam logic CTRL_UP_RESET = 1'b1;
  localparam int ST_BUSY   = 0;
  localparam int ST_BUS8   = 1;
  localparam int ST_TWO    = 2;
  localparam int ST_FONT   = 3;
  localparam int ST_GLYPH  = 4;
  localparam int ST_AC_LSB = 8;

  typedef struct packed {
    logic       e;
    logic       rs;
    logic       rw;
    logic [7:0] db;
  } pins_t;

  typedef struct packed {
    logic bus8;
    logic two_line;
    logic tall_font;
  } mode_t;

  localparam pins_t PINS_RESET = '0;
  localparam mode_t MODE_RESET = '{bus8: 1'b1, two_line: 1'b0,
                                   tall_font: 1'b0};

endpackage : text_display_pkg

// File: rtl/text_display_port.sv
// Command interpreter behind the character display's parallel host port.
//
// The register offsets and register access over Wishbone were decided locally.
module text_display_port
  import text_display_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire pins_t       pins_i,
  output logic      [7:0]  db_o,
  output logic             db_oe_n_o,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        disp_line_i,
  input  wire logic [3:0]  disp_pos_i,
  output logic      [7:0]  disp_char_o,
  output logic             two_line_o,
  output logic             tall_font_o,
  output logic             busy_o
);

  pins_t             sync1_r, sync2_r, sample_r, sample_nxt;
  logic              e_d_r;
  logic              nib_r, nib_nxt;
  logic [3:0]        hi_r, hi_nxt;
  logic [6:0]        ac_r, ac_nxt, stepped, shifted;
  logic              glyph_sel_r, glyph_sel_nxt;
  logic [7:0]        latch_r, latch_nxt;
  mode_t             mode_r, mode_nxt;
  logic [BUSY_W-1:0] busy_cnt_r, busy_cnt_nxt;
  logic              busy_r, busy_nxt;
  logic              entry_up_r, entry_up_nxt;
  logic [7:0]        db_nxt, src, status_byte, byte_w;
  logic              oe_n_nxt, fall, byte_done;
  logic              instr_wr, data_wr, data_rd;
  logic              ack_nxt, reg_wr;
  logic [31:0]       dat_nxt;
  logic [6:0]        disp_addr;
  logic [7:0]        disp_nxt;
  logic [7:0]        text_ram  [TEXT_DEPTH];
  logic [7:0]        glyph_ram [GLYPH_DEPTH];

  // Next counter value; text RAM wraps across the unused gap per line mode.
  function automatic logic [6:0] step_addr(input logic [6:0] a,
                                           input logic       up,
                                           input logic       two,
                                           input logic       glyph);
    logic [6:0] n;
    n = a;
    if (glyph) begin
      n = up ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
    end else if (two) begin
      if (up) begin
        n = (a == LINE1_END) ? LINE2_START :
            (a == LINE2_END) ? ADDR_FIRST : a + ADDR_ONE;
      end else begin
        n = (a == ADDR_FIRST)  ? LINE2_END :
            (a == LINE2_START) ? LINE1_END : a - ADDR_ONE;
      end
    end else begin
      if (up) begin
        n = (a == ONE_LINE_END) ? ADDR_FIRST : a + ADDR_ONE;
      end else begin
        n = (a == ADDR_FIRST) ? ONE_LINE_END : a - ADDR_ONE;
      end
    end
    return n;
  endfunction : step_addr

  // Pins are asynchronous to clk_i, so two stages come before any use.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= PINS_RESET;
      sync2_r <= PINS_RESET;
    end else if (ce_i) begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
    end
  end

  // The last sample with the strobe high is used, so no hold is needed.
  always_comb begin
    sample_nxt = sync2_r.e ? sync2_r : sample_r;
    fall       = e_d_r & ~sync2_r.e;
    byte_done  = fall & (mode_r.bus8 | nib_r);
    byte_w     = mode_r.bus8 ? sample_r.db : {hi_r, sample_r.db[7:4]};
    nib_nxt    = nib_r;
    hi_nxt     = hi_r;
    if (fall && !mode_r.bus8) begin
      nib_nxt = ~nib_r;
      if (!nib_r) begin
        hi_nxt = sample_r.db[7:4];
      end
    end
    instr_wr = byte_done & ~sample_r.rs & ~sample_r.rw & ~busy_r;
    data_wr  = byte_done &  sample_r.rs & ~sample_r.rw & ~busy_r;
    data_rd  = byte_done &  sample_r.rs &  sample_r.rw & ~busy_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_r <= PINS_RESET;
      e_d_r    <= 1'b0;
      nib_r    <= 1'b0;
      hi_r     <= 4'h0;
    end else if (ce_i) begin
      sample_r <= sample_nxt;
      e_d_r    <= sync2_r.e;
      nib_r    <= nib_nxt;
      hi_r     <= hi_nxt;
    end
  end

  // Command execution: address counter, RAM select, read register, mode.
  always_comb begin
    stepped = step_addr(ac_r, entry_up_r, mode_r.two_line, glyph_sel_r);
    shifted = step_addr(ac_r, byte_w[BIT_SHIFT_RL], mode_r.two_line,
                        glyph_sel_r);
    ac_nxt        = ac_r;
    glyph_sel_nxt = glyph_sel_r;
    latch_nxt     = latch_r;
    mode_nxt      = mode_r;
    busy_cnt_nxt  = (busy_cnt_r != '0) ? busy_cnt_r - 1'b1 : busy_cnt_r;
    if (instr_wr) begin
      busy_cnt_nxt = INSTR_CYC;
      if (byte_w[BIT_TEXT_SET]) begin
        ac_nxt        = byte_w[6:0];
        glyph_sel_nxt = 1'b0;
        latch_nxt     = text_ram[byte_w[6:0]];
      end else if (byte_w[BIT_GLYPH_SET]) begin
        ac_nxt        = {1'b0, byte_w[5:0]};
        glyph_sel_nxt = 1'b1;
        latch_nxt     = glyph_ram[byte_w[5:0]];
      end else if (byte_w[BIT_FUNC_SET]) begin
        mode_nxt.bus8      = byte_w[BIT_BUS8];
        mode_nxt.two_line  = byte_w[BIT_LINES];
        mode_nxt.tall_font = byte_w[BIT_FONT];
      end else if (byte_w[BIT_SHIFT_OP] && !byte_w[BIT_SHIFT_SC]) begin
        ac_nxt = shifted;
        if (!glyph_sel_r) begin
          latch_nxt = text_ram[shifted];
        end
      end
    end else if (data_wr) begin
      ac_nxt       = stepped;
      busy_cnt_nxt = DATA_CYC;
    end else if (data_rd) begin
      ac_nxt       = stepped;
      busy_cnt_nxt = DATA_CYC;
      latch_nxt    = glyph_sel_r ? glyph_ram[stepped[5:0]]
                                 : text_ram[stepped];
    end
    busy_nxt = (busy_cnt_nxt != '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ac_r        <= ADDR_FIRST;
      glyph_sel_r <= 1'b0;
      latch_r     <= 8'h00;
      mode_r      <= MODE_RESET;
      busy_cnt_r  <= '0;
      busy_r      <= 1'b0;
    end else if (ce_i) begin
      ac_r        <= ac_nxt;
      glyph_sel_r <= glyph_sel_nxt;
      latch_r     <= latch_nxt;
      mode_r      <= mode_nxt;
      busy_cnt_r  <= busy_cnt_nxt;
      busy_r      <= busy_nxt;
    end
  end

  // RAM contents are not reset; software must load them before use.
  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_i && data_wr) begin
      if (glyph_sel_r) begin
        glyph_ram[ac_r[5:0]] <= byte_w;
      end else begin
        text_ram[ac_r] <= byte_w;
      end
    end
  end

  // Read drive and the display scan port.
  always_comb begin
    status_byte = {busy_r, ac_r};
    src         = sync2_r.rs ? latch_r : status_byte;
    db_nxt      = mode_r.bus8 ? src
                : {(nib_r ? src[3:0] : src[7:4]), 4'h0};
    oe_n_nxt    = ~(sync2_r.e & sync2_r.rw);
    disp_addr   = (disp_line_i ? LINE2_START : ADDR_FIRST)
                + {3'h0, disp_pos_i};
    disp_nxt    = text_ram[disp_addr];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      db_o        <= 8'h00;
      db_oe_n_o   <= 1'b1;
      disp_char_o <= 8'h00;
    end else if (ce_i) begin
      db_o        <= db_nxt;
      db_oe_n_o   <= oe_n_nxt;
      disp_char_o <= disp_nxt;
    end
  end

  // Wishbone slave: answers every access one cycle after it starts.
  always_comb begin
    ack_nxt      = cyc_i & stb_i & ~ack_o;
    reg_wr       = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    entry_up_nxt = entry_up_r;
    if (reg_wr && adr_i == REG_CTRL) begin
      entry_up_nxt = dat_i[CTRL_UP_BIT];
    end
    dat_nxt = 32'h0000_0000;
    case (adr_i)
      REG_CTRL: begin
        dat_nxt[CTRL_UP_BIT] = entry_up_r;
      end
      REG_STATUS: begin
        dat_nxt[ST_BUSY]               = busy_r;
        dat_nxt[ST_BUS8]               = mode_r.bus8;
        dat_nxt[ST_TWO]                = mode_r.two_line;
        dat_nxt[ST_FONT]               = mode_r.tall_font;
        dat_nxt[ST_GLYPH]              = glyph_sel_r;
        dat_nxt[ST_AC_LSB +: 7]        = ac_r;
      end
      default: begin
        dat_nxt = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
      entry_up_r <= CTRL_UP_RESET;
    end else if (ce_i) begin
      ack_o      <= ack_nxt;
      dat_o      <= dat_nxt;
      entry_up_r <= entry_up_nxt;
    end
  end

  assign two_line_o  = mode_r.two_line;
  assign tall_font_o = mode_r.tall_font;
  assign busy_o      = busy_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  instr_busy_a: assert property (ce_i && instr_wr |=>
    busy_cnt_r == INSTR_CYC && busy_r) else $error("instr busy wrong");
  data_busy_a: assert property (ce_i && (data_wr || data_rd) |=>
    busy_cnt_r == DATA_CYC && busy_r) else $error("data busy wrong");
  status_read_a: assert property (ce_i && mode_r.bus8 && !sync2_r.rs
    |=> db_o == $past(status_byte)) else $error("status byte wrong");
  text_load_a: assert property (ce_i && instr_wr && byte_w[7]
    |=> ac_r == $past(byte_w[6:0]) && !glyph_sel_r)
    else $error("text address load wrong");
  glyph_load_a: assert property (ce_i && instr_wr
    && byte_w[7:6] == 2'b01
    |=> ac_r[5:0] == $past(byte_w[5:0]) && glyph_sel_r)
    else $error("glyph address load wrong");
  line_wrap_a: assert property (ce_i && data_wr && !glyph_sel_r
    && mode_r.two_line && entry_up_r && ac_r == LINE1_END
    |=> ac_r == LINE2_START) else $error("two-line wrap wrong");
  one_wrap_a: assert property (ce_i && data_wr && !glyph_sel_r
    && !mode_r.two_line && entry_up_r && ac_r == ONE_LINE_END
    |=> ac_r == ADDR_FIRST) else $error("one-line wrap wrong");
  write_step_a: assert property (ce_i && data_wr && !glyph_sel_r
    && !mode_r.two_line && entry_up_r && ac_r < ONE_LINE_END
    |=> ac_r == $past(ac_r) + ADDR_ONE) else $error("write step wrong");
  stale_read_a: assert property (ce_i && data_wr
    |=> $stable(latch_r)) else $error("read register changed on write");
  nibble_first_a: assert property (ce_i && fall && !mode_r.bus8
    && !nib_r |-> !byte_done ##1 (nib_r
    && hi_r == $past(sample_r.db[7:4])))
    else $error("half byte taken as whole");
  mode_set_a: assert property (ce_i && instr_wr
    && byte_w[7:5] == 3'b001 |=> two_line_o == $past(byte_w[3])
    && tall_font_o == $past(byte_w[2])) else $error("mode set wrong");

endmodule : text_display_port

// File: dv/host_model.sv
// Host processor model driving the display's parallel instruction port.
module host_model
  import text_display_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] db_i,
  input  wire logic       db_oe_n_i,
  output pins_t           pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       e, rs, rw, hen;
  logic [7:0] hdb, last_db;

  // A released bus never keeps its last value, so a stale read shows.
  assign pins_o = '{e: e, rs: rs, rw: rw,
                    db: !db_oe_n_i ? db_i : hen ? hdb : ~last_db};

  always @(posedge clk_i) begin
    last_db <= pins_o.db;
  end

  initial begin
    e = 1'b0;
    rs = 1'b0;
    rw = 1'b0;
    hen = 1'b0;
    hdb = 8'h00;
    last_db = 8'h00;
  end

  task automatic xfer(input logic rs_v, input logic rw_v, input logic bus8,
                      input logic [7:0] wv, output logic [7:0] rv);
    int n;
    rv = 8'h00;
    for (n = 0; n < (bus8 ? 1 : 2); n++) begin
      @(posedge clk_i);
      rs <= rs_v;
      rw <= rw_v;
      hen <= !rw_v;
      hdb <= (bus8 || n == 0) ? wv : {wv[3:0], 4'h0};
      e <= 1'b1;
      repeat (6) @(posedge clk_i);
      if (bus8) rv = db_i;
      else if (n == 0) rv[7:4] = db_i[7:4];
      else rv[3:0] = db_i[7:4];
      e <= 1'b0;
      repeat (6) @(posedge clk_i);
      hen <= 1'b0;
    end
  endtask : xfer
endmodule : host_model

// File: dv/testbench.sv
// Self-checking bench for the text display command port.
module testbench
  import text_display_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] CORNER [4] = '{7'h27, 7'h67, 7'h0f, 7'h4f};
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, disp_line_i, bus8;
  logic [3:0]  adr_i, sel_i, disp_pos_i;
  logic [31:0] dat_i, dat_o, q;
  logic [7:0]  db_o, disp_char_o, r, rv, d, d2;
  logic [6:0]  a;
  logic        db_oe_n_o, ack_o, two_line_o, tall_font_o, busy_o;
  pins_t       pins;
  logic [7:0]  txt [128];
  int          n_mismatch, comparisons, run, last_run, i;

  text_display_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .pins_i(pins), .db_o(db_o), .db_oe_n_o(db_oe_n_o), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .disp_line_i(disp_line_i),
    .disp_pos_i(disp_pos_i), .disp_char_o(disp_char_o),
    .two_line_o(two_line_o), .tall_font_o(tall_font_o), .busy_o(busy_o));
  host_model u_host (.clk_i(clk_i), .db_i(db_o), .db_oe_n_i(db_oe_n_o),
    .pins_o(pins));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Length of the latest busy period in clocks.
  always @(posedge clk_i) begin
    if (busy_o === 1'b1) run++;
    else if (run != 0) begin
      last_run = run;
      run = 0;
    end
  end

  function automatic logic [6:0] nxt(input logic [6:0] v);
    return v == 7'h27 ? 7'h40 : v == 7'h67 ? 7'h00 : v + 7'h01;
  endfunction : nxt

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results(input logic hang);
    if (hang) n_mismatch++;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dv);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= dv;
    for (k = 0; k < 20 && ack_o !== 1'b1; k++) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k == 20) results(1'b1);
  endtask : wb

  task automatic hx(input logic rs_v, input logic rw_v, input logic [7:0] wv);
    u_host.xfer(rs_v, rw_v, bus8, wv, r);
  endtask : hx

  task automatic ready();
    int k;
    for (k = 0; k < 200; k++) begin
      hx(1'b0, 1'b1, 8'h00);
      if (r[7] === 1'b0) break;
    end
    if (k == 200) results(1'b1);
  endtask : ready

  task automatic op(input logic rs_v, input logic rw_v, input logic [7:0] wv);
    hx(rs_v, rw_v, wv);
    rv = r;
    check(32'(busy_o), 32'h1);
    hx(1'b0, 1'b1, 8'h00);
    check(32'(r[7]), 32'h1);
    ready();
  endtask : op

  task automatic ac_check(input logic [6:0] ex);
    hx(1'b0, 1'b1, 8'h00);
    check(32'(r), 32'(ex));
  endtask : ac_check

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    dat_i = 32'h0;
    sel_i = 4'hf;
    disp_line_i = 1'b0;
    disp_pos_i = 4'h0;
    bus8 = 1'b1;
    run = 0;
    last_run = 0;
    void'($urandom(67));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_STATUS, 32'h0);
    check(q, 32'h2);
    wb(1'b0, 4'h8, 32'h0);
    check(q, 32'h0);
    op(1'b0, 1'b0, 8'h3c);
    check(32'(two_line_o), 32'h1);
    check(32'(tall_font_o), 32'h1);
    check(last_run, 32'd390);
    for (i = 0; i < 8; i++) begin
      a = (i < 4) ? CORNER[i] : {1'($urandom), 6'($urandom_range(39, 0))};
      d = 8'($urandom);
      op(1'b0, 1'b0, {1'b1, a});
      ac_check(a);
      op(1'b1, 1'b0, d);
      txt[a] = d;
      check(last_run, 32'd430);
      ac_check(nxt(a));
      op(1'b0, 1'b0, {1'b1, a});
      op(1'b1, 1'b1, 8'h00);
      check(32'(rv), 32'(d));
      ac_check(nxt(a));
    end
    op(1'b0, 1'b0, 8'ha7);
    op(1'b1, 1'b0, 8'h5a);
    op(1'b1, 1'b1, 8'h00);
    check(32'(rv), 32'(txt[7'h27]));
    op(1'b0, 1'b0, 8'hc0);
    op(1'b0, 1'b0, 8'h10);
    ac_check(7'h27);
    op(1'b1, 1'b1, 8'h00);
    check(32'(rv), 32'h5a);
    for (i = 0; i < 2; i++) begin
      disp_line_i <= i[0];
      disp_pos_i <= 4'hf;
      repeat (2) @(posedge clk_i);
      check(32'(disp_char_o), 32'(txt[{i[0], 6'h0f}]));
    end
    wb(1'b1, REG_CTRL, 32'h0);
    op(1'b0, 1'b0, 8'hc0);
    op(1'b1, 1'b0, 8'h33);
    ac_check(7'h27);
    wb(1'b1, REG_CTRL, 32'h1);
    d = 8'($urandom);
    op(1'b0, 1'b0, 8'h7f);
    op(1'b1, 1'b0, d);
    ac_check(7'h00);
    wb(1'b0, REG_STATUS, 32'h0);
    check(32'(q[ST_GLYPH]), 32'h1);
    op(1'b0, 1'b0, 8'h7f);
    op(1'b1, 1'b1, 8'h00);
    check(32'(rv), 32'(d));
    op(1'b0, 1'b0, 8'h30);
    check(32'(two_line_o), 32'h0);
    check(32'(tall_font_o), 32'h0);
    op(1'b0, 1'b0, 8'hce);
    op(1'b1, 1'b0, 8'h66);
    ac_check(7'h4f);
    op(1'b1, 1'b0, 8'h77);
    ac_check(7'h00);
    hx(1'b0, 1'b0, 8'h28);
    bus8 = 1'b0;
    ready();
    wb(1'b0, REG_STATUS, 32'h0);
    check(32'(q[ST_BUS8]), 32'h0);
    d = 8'($urandom);
    d2 = 8'($urandom);
    op(1'b0, 1'b0, 8'h85);
    op(1'b1, 1'b0, d);
    ac_check(7'h06);
    op(1'b1, 1'b0, d2);
    wb(1'b1, REG_CTRL, 32'h0);
    // first read is stale and dropped
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    check(32'(rv), 32'(d2));
    ac_check(7'h05);
    wb(1'b1, REG_CTRL, 32'h1);
    op(1'b0, 1'b0, 8'h85);
    op(1'b1, 1'b1, 8'h00);
    check(32'(rv), 32'(d));
    results(1'b0);
  end
endmodule : testbench
